// File: verilog/ems_core.sv
/*
  Status, interrupt and PHY management logic of a 10/100 MAC.
  Assumes synchronous inputs, one clock, and DMA/transmit event pulses
  from the surrounding MAC; the MDIO wire is resolved outside.
*/
`timescale 1ns/1ps
module ems_core
  import ems_pkg::*;
(
  input  wire logic        CLK,          // System clock, 200 MHz
  input  wire logic        RST,          // Synchronous reset, active high
  input  wire logic [7:0]  ADDR,         // Register byte address
  input  wire logic [31:0] WDATA,        // Write data
  input  wire logic        WR,           // Write strobe
  input  wire logic        RD,           // Read strobe
  output logic      [31:0] RDATA,        // Read data, cycle after strobe
  input  wire logic        TX_UNDERRUN,  // Transmit DMA late pulse
  input  wire logic        RX_DESC_FAIL, // Descriptor owned by processor
  input  wire logic        RX_DESC_OK,   // Descriptor taken, advance
  input  wire logic        RX_STORED,    // Frame written to memory
  input  wire logic        RX_OVERRUN,   // Frame lost to bus trouble
  input  wire logic        TX_WRITE,     // Software wrote tx addr/ctrl
  input  wire logic        TX_SLOT_FREE, // Transmit slot free status
  input  wire logic        TX_DONE,      // One frame sent
  input  wire logic        TX_ALL_DONE,  // Queue drained
  input  wire logic        TX_RETRY,     // Retry limit reached
  input  wire logic        DMA_ABORT,    // DMA transfer aborted
  input  wire logic        LINK,         // Link pin level
  input  wire logic        MDIO_I,       // Management data in
  output logic             MDIO_O,       // Management data out
  output logic             MDIO_OE,      // High while driving MDIO
  output logic             MDC,          // Management clock
  output logic             CRC_CORRUPT,  // Force bad CRC on underrun
  output logic             RX_RECLAIM,   // Give back overrun buffer
  output logic [31:0]      RX_PTR,       // Current buffer pointer
  output logic             IRQ           // Interrupt to processor
);

  // Shifter states, Gray coded
  typedef enum logic [1:0] {
    EMS_IDLE  = 2'b00,
    EMS_SHIFT = 2'b01,
    EMS_DONE  = 2'b11
  } ems_state_type;

  // All state of the block
  typedef struct packed {
    logic [31:0]          qptr;
    logic [2:0]           rxf;
    logic [IRQ_COUNT-1:0] pend;
    logic [IRQ_COUNT-1:0] mask;
    logic [31:0]          shreg;
    logic [5:0]           bitcnt;
    logic [5:0]           divcnt;
    logic                 mdc;
    ems_state_type        st;
    logic                 port_en;
    logic [1:0]           div;
    logic                 link_d;
    logic                 link_seen;
    logic                 slot_d;
    logic [31:0]          rdata;
    logic                 mdo;
    logic                 mdoe;
    logic                 crc_bad;
    logic                 reclaim;
    logic                 irq;
  } ems_state_s_type;

  ems_state_s_type s_reg;  // Registered state
  ems_state_s_type s_next; // Next state

  // Half period of MDC in system clocks for a divider code
  function automatic logic [5:0] half_period(input logic [1:0] code);
    half_period = HALF_BASE << code;
  endfunction : half_period

  logic [31:0] wmask;  // Write-one mask for W1C fields
  logic        edge_en; // One-cycle pulse at each MDC edge
  logic        busy;    // Shifter running
  assign wmask   = WDATA;
  assign busy    = (s_reg.st != EMS_IDLE);
  assign edge_en = (s_reg.divcnt == half_period(s_reg.div) - 6'h01);

  // Next-state logic
  always_comb begin
    logic [IRQ_COUNT-1:0] ev;
    logic                 wr_man;
    ev     = '0;
    s_next = s_reg;
    wr_man = WR && (ADDR == OFS_PHY_MGMT_FRAME);
    s_next.crc_bad = TX_UNDERRUN;
    s_next.reclaim = RX_OVERRUN;

    // Receive queue pointer
    if (WR && ADDR == OFS_RX_QUEUE_POINTER) begin
      s_next.qptr = {WDATA[31:2], 2'b00};
    end else if (RX_DESC_OK) begin
      s_next.qptr = s_reg.qptr + 32'h0000_0008;
    end

    // Receive flags: write-one clear, set wins
    if (WR && ADDR == OFS_RX_EVENT_FLAGS) begin
      s_next.rxf = s_reg.rxf & ~wmask[2:0];
    end
    if (RX_DESC_FAIL) begin
      s_next.rxf[RXF_NO_BUFFER] = 1'b1;
    end
    if (RX_STORED) begin
      s_next.rxf[RXF_STORED] = 1'b1;
    end
    if (RX_OVERRUN) begin
      s_next.rxf[RXF_OVERRUN] = 1'b1;
    end

    // Interrupt events
    s_next.link_d    = LINK;
    s_next.link_seen = 1'b1;
    ev[IRQ_RX_COMP]  = RX_STORED;
    ev[IRQ_TX_UND]   = TX_UNDERRUN;
    ev[IRQ_RX_NOBUF] = RX_DESC_FAIL;
    ev[IRQ_TX_QOVR]  = TX_WRITE && !TX_SLOT_FREE;
    // Slot free raises its bit only on a rising status level
    s_next.slot_d    = TX_SLOT_FREE;
    ev[IRQ_TX_FREE]  = TX_SLOT_FREE && !s_reg.slot_d;
    ev[IRQ_TX_COMP]  = TX_DONE;
    ev[IRQ_TX_ALL]   = TX_ALL_DONE;
    ev[IRQ_RETRY]    = TX_RETRY;
    ev[IRQ_RX_OVR]   = RX_OVERRUN;
    ev[IRQ_ABORT]    = DMA_ABORT;
    ev[IRQ_LINK]     = s_reg.link_seen && (LINK != s_reg.link_d);
    ev[IRQ_DONE]     = (s_reg.st == EMS_DONE);

    // Pending: clear on read, set wins over the clear
    if (RD && ADDR == OFS_IRQ_PENDING) begin
      s_next.pend = '0;
    end
    if (!TX_SLOT_FREE) begin
      s_next.pend[IRQ_TX_FREE] = 1'b0;
    end
    s_next.pend = s_next.pend | ev;

    // Enable and disable writes act on the inverted mask
    if (WR && ADDR == OFS_IRQ_ENABLE_SET) begin
      s_next.mask = s_reg.mask & ~WDATA[IRQ_COUNT-1:0];
    end
    if (WR && ADDR == OFS_IRQ_ENABLE_CLEAR) begin
      s_next.mask = s_reg.mask | WDATA[IRQ_COUNT-1:0];
    end
    s_next.irq = |(s_next.pend & ~s_next.mask);

    // Management control
    if (WR && ADDR == OFS_MGMT_CONTROL) begin
      s_next.port_en = WDATA[CTL_PORT_EN];
      s_next.div     = WDATA[CTL_DIV_LO +: 2];
    end

    // MDC divider, runs only while shifting
    s_next.divcnt = '0;
    s_next.mdc    = 1'b0;
    if (s_reg.st == EMS_SHIFT) begin
      s_next.divcnt = edge_en ? 6'h00 : s_reg.divcnt + 6'h01;
      s_next.mdc    = edge_en ? !s_reg.mdc : s_reg.mdc;
    end

    // Shifter
    unique case (s_reg.st)
      EMS_IDLE: begin
        if (wr_man) begin
          s_next.shreg  = WDATA;
          s_next.bitcnt = '0;
          s_next.st     = EMS_SHIFT;
          s_next.mdo    = WDATA[FRAME_BITS-1];
        end
      end
      EMS_SHIFT: begin
        // Rising MDC: sample line into LSB, then shift out next MSB
        if (edge_en && !s_reg.mdc) begin
          s_next.shreg = {s_reg.shreg[30:0], MDIO_I};
          s_next.mdo   = s_reg.shreg[30];
          if (s_reg.bitcnt == SHIFT_LAST) begin
            s_next.st = EMS_DONE;
          end
          s_next.bitcnt = s_reg.bitcnt + 6'h01;
        end
      end
      EMS_DONE: begin
        s_next.st = EMS_IDLE;
      end
      default: s_next.st = EMS_IDLE;
    endcase
    // Writes while busy fall through untouched
    s_next.mdoe = s_next.port_en && (s_next.st == EMS_SHIFT);

    // Read data
    s_next.rdata = '0;
    if (RD) begin
      unique case (ADDR)
        OFS_RX_QUEUE_POINTER:  s_next.rdata = s_reg.qptr;
        OFS_RX_EVENT_FLAGS:    s_next.rdata = {29'h0, s_reg.rxf};
        OFS_IRQ_PENDING:       s_next.rdata = {20'h0, s_reg.pend};
        OFS_IRQ_DISABLED_VIEW: s_next.rdata = {20'h0, s_reg.mask};
        OFS_PHY_MGMT_FRAME:    s_next.rdata = s_reg.shreg;
        OFS_MGMT_CONTROL:      s_next.rdata = {29'h0, s_reg.div,
                                               s_reg.port_en};
        OFS_MGMT_STATUS:       s_next.rdata = {29'h0, busy, MDIO_I,
                                               LINK};
        default:               s_next.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_reg         <= '0;
      s_reg.mask    <= MASK_RESET;
      s_reg.div     <= DIV_RESET;
      s_reg.port_en <= CTL_PORT_EN_RESET;
      s_reg.st      <= EMS_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign RDATA       = s_reg.rdata;
  assign MDIO_O      = s_reg.mdo;
  assign MDIO_OE     = s_reg.mdoe;
  assign MDC         = s_reg.mdc;
  assign CRC_CORRUPT = s_reg.crc_bad;
  assign RX_RECLAIM  = s_reg.reclaim;
  assign RX_PTR      = s_reg.qptr;
  assign IRQ         = s_reg.irq;

  // Assertions
  underrun_crc_a: assert property (@(posedge CLK) disable iff (RST)
    TX_UNDERRUN |=> CRC_CORRUPT && s_reg.pend[IRQ_TX_UND])
    else $error("underrun did not corrupt crc");
  qptr_align_a: assert property (@(posedge CLK) disable iff (RST)
    RX_PTR[1:0] == 2'b00)
    else $error("queue pointer not word aligned");
  nobuf_set_a: assert property (@(posedge CLK) disable iff (RST)
    RX_DESC_FAIL |=> s_reg.rxf[RXF_NO_BUFFER]
      && s_reg.pend[IRQ_RX_NOBUF])
    else $error("no-buffer flag missed");
  stored_hold_a: assert property (@(posedge CLK) disable iff (RST)
    s_reg.rxf[RXF_STORED] && !(WR && ADDR == OFS_RX_EVENT_FLAGS)
      |=> s_reg.rxf[RXF_STORED])
    else $error("stored flag dropped");
  irq_out_a: assert property (@(posedge CLK) disable iff (RST)
    IRQ == |(s_reg.pend & ~s_reg.mask))
    else $error("interrupt output wrong");
  enable_set_a: assert property (@(posedge CLK) disable iff (RST)
    WR && ADDR == OFS_IRQ_ENABLE_SET && WDATA[0] |=> !s_reg.mask[0])
    else $error("enable write failed");
  disable_set_a: assert property (@(posedge CLK) disable iff (RST)
    WR && ADDR == OFS_IRQ_ENABLE_CLEAR && WDATA[0] |=> s_reg.mask[0])
    else $error("disable write failed");
  busy_ignore_a: assert property (@(posedge CLK) disable iff (RST)
    busy && s_reg.bitcnt != 6'h00 && WR && ADDR == OFS_PHY_MGMT_FRAME
      |=> s_reg.bitcnt != 6'h00)
    else $error("shifter restarted while busy");
  done_pend_a: assert property (@(posedge CLK) disable iff (RST)
    s_reg.st == EMS_DONE |=> s_reg.pend[IRQ_DONE] && !busy)
    else $error("done not flagged");
  mdio_release_a: assert property (@(posedge CLK) disable iff (RST)
    !s_reg.port_en |-> !MDIO_OE)
    else $error("mdio driven while port disabled");

  frame_cov_c: cover property (@(posedge CLK) s_reg.st == EMS_DONE);
  irq_cov_c:   cover property (@(posedge CLK) IRQ);
  nobuf_cov_c: cover property (@(posedge CLK) RX_DESC_FAIL ##1 RX_DESC_FAIL);
  slot_cov_c:  cover property (@(posedge CLK) s_reg.pend[IRQ_TX_FREE]);
  link_cov_c:  cover property (@(posedge CLK) s_reg.pend[IRQ_LINK]);

  // Overrun gives the buffer back and raises flag and pending bit
  overrun_flag_a: assert property (
    @(posedge CLK) disable iff (RST)
    RX_OVERRUN |=> RX_RECLAIM && s_reg.rxf[RXF_OVERRUN]
      && s_reg.pend[IRQ_RX_OVR])
    else $error("overrun not flagged");

  // A stored frame raises its flag and its pending bit together
  rx_comp_a: assert property (
    @(posedge CLK) disable iff (RST)
    RX_STORED |=> s_reg.rxf[RXF_STORED] && s_reg.pend[IRQ_RX_COMP])
    else $error("receive complete not flagged");

  // Transmit write while the slot is taken is an overrun
  queue_ovr_a: assert property (
    @(posedge CLK) disable iff (RST)
    TX_WRITE && !TX_SLOT_FREE |=> s_reg.pend[IRQ_TX_QOVR])
    else $error("queue overrun not flagged");

  // Slot free pending cannot survive a taken slot
  slot_clear_a: assert property (
    @(posedge CLK) disable iff (RST)
    !TX_SLOT_FREE |=> !s_reg.pend[IRQ_TX_FREE])
    else $error("slot free pending not cleared");

  // Each sent frame raises transmit complete
  tx_comp_a: assert property (
    @(posedge CLK) disable iff (RST)
    TX_DONE |=> s_reg.pend[IRQ_TX_COMP])
    else $error("transmit complete not flagged");

  // A drained queue raises all done
  tx_all_a: assert property (
    @(posedge CLK) disable iff (RST)
    TX_ALL_DONE |=> s_reg.pend[IRQ_TX_ALL])
    else $error("transmit all done not flagged");

  // Exhausted retries raise the retry bit
  retry_pend_a: assert property (
    @(posedge CLK) disable iff (RST)
    TX_RETRY |=> s_reg.pend[IRQ_RETRY])
    else $error("retry limit not flagged");

  // An aborted transfer raises the abort bit
  abort_pend_a: assert property (
    @(posedge CLK) disable iff (RST)
    DMA_ABORT |=> s_reg.pend[IRQ_ABORT])
    else $error("abort not flagged");

  // Any change of the link pin raises the link bit
  link_pend_a: assert property (
    @(posedge CLK) disable iff (RST)
    s_reg.link_seen && LINK != s_reg.link_d |=> s_reg.pend[IRQ_LINK])
    else $error("link change not flagged");

  // A write while idle loads the whole frame and starts shifting
  frame_start_a: assert property (
    @(posedge CLK) disable iff (RST)
    !busy && WR && ADDR == OFS_PHY_MGMT_FRAME
      |=> s_reg.st == EMS_SHIFT && s_reg.shreg == $past(WDATA))
    else $error("frame did not start");

  // While shifting, the line carries the top bit of the shifter
  msb_out_a: assert property (
    @(posedge CLK) disable iff (RST)
    s_reg.st == EMS_SHIFT |-> MDIO_O == s_reg.shreg[31])
    else $error("line not driven from msb");

  // Each rising management clock takes the line into the lsb
  lsb_in_a: assert property (
    @(posedge CLK) disable iff (RST)
    s_reg.st == EMS_SHIFT && edge_en && !s_reg.mdc
      |=> s_reg.shreg[0] == $past(MDIO_I))
    else $error("line not sampled into lsb");

  // Status read shows the shifter busy bit of the strobe cycle
  busy_view_a: assert property (
    @(posedge CLK) disable iff (RST)
    RD && ADDR == OFS_MGMT_STATUS |=> RDATA[2] == $past(busy))
    else $error("busy status wrong");

  // Mask view reads the disabled set, ones meaning off
  mask_view_a: assert property (
    @(posedge CLK) disable iff (RST)
    RD && ADDR == OFS_IRQ_DISABLED_VIEW
      |=> RDATA == {20'h0, $past(s_reg.mask)})
    else $error("mask view wrong");

  // Divider counter never passes the half period of its code
  mdc_rate_a: assert property (
    @(posedge CLK) disable iff (RST)
    s_reg.st == EMS_SHIFT |-> s_reg.divcnt < half_period(s_reg.div))
    else $error("management clock divider overran");

  // Done lasts one cycle and returns the shifter to idle
  done_once_a: assert property (
    @(posedge CLK) disable iff (RST)
    s_reg.st == EMS_DONE |=> s_reg.st == EMS_IDLE)
    else $error("done state stuck");
endmodule : ems_core

// File: verilog/ems_pkg.sv
/*
  Constants for the status, interrupt and PHY management block.
  Assumes a 200 MHz system clock and a 32-bit register port.
*/
// Contract
// - Transmit underrun sets flag, CRC corrupted, W1C; the block keeps only a read-clear pending bit
// - Queue pointer write loads start, word aligned
// - Processor-owned descriptor sets no-buffer flag
// - No-buffer flag set on every failed attempt
// - Frame stored flag set, write one clears
// - Receive overrun sets flag, buffer reclaimed
// - Management done pending bit, clear on read
// - Receive complete and underrun pending, read clears
// - Transmit write while slot busy sets overrun
// - Slot free pending clears when queue full
// - Complete, all done, retry limit pending bits
// - Overrun and abort pending bits, read clears
// - Link pin change sets link pending bit
// - Enable register: ones enable, zeros ignored
// - Disable register: ones disable, zeros ignored
// - Mask view reads one when disabled
// - Maintenance write starts 32-bit shift
// - Drive MSB out, sample line into LSB
// - Finish raises done and idle indication
// - Data field holds PHY answer after read
// - Management clock divider 8/16/32/64, reset 32
// - Port disabled releases the MDIO line
// - Busy status one while shifting
package ems_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_RX_QUEUE_POINTER  = 8'h00;
  localparam logic [7:0] OFS_RX_EVENT_FLAGS    = 8'h04;
  localparam logic [7:0] OFS_IRQ_PENDING       = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_DISABLED_VIEW = 8'h14;
  localparam logic [7:0] OFS_PHY_MGMT_FRAME    = 8'h18;
  localparam logic [7:0] OFS_MGMT_CONTROL      = 8'h1C;
  localparam logic [7:0] OFS_MGMT_STATUS       = 8'h20;
  // Receive flag positions
  localparam int RXF_NO_BUFFER = 0;
  localparam int RXF_STORED    = 1;
  localparam int RXF_OVERRUN   = 2;
  // Pending bit positions
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_RX_COMP   = 1;
  localparam int IRQ_RX_NOBUF  = 2;
  localparam int IRQ_TX_QOVR   = 3;
  localparam int IRQ_TX_UND    = 4;
  localparam int IRQ_RETRY     = 5;
  localparam int IRQ_TX_FREE   = 6;
  localparam int IRQ_TX_COMP   = 7;
  localparam int IRQ_TX_ALL    = 8;
  localparam int IRQ_LINK      = 9;
  localparam int IRQ_RX_OVR    = 10;
  localparam int IRQ_ABORT     = 11;
  localparam int IRQ_COUNT     = 12;
  // Control register fields
  localparam int CTL_PORT_EN   = 0;
  localparam int CTL_DIV_LO    = 1;
  localparam logic [1:0] DIV_RESET = 2'h2;
  localparam logic       CTL_PORT_EN_RESET = 1'b0;
  // All sources start disabled
  localparam logic [11:0] MASK_RESET = 12'hFFF;
  // Frame length and divider widths
  localparam int          FRAME_BITS = 32;
  localparam logic [5:0]  SHIFT_LAST = 6'h1F;
  localparam logic [5:0]  HALF_BASE  = 6'h04;
endpackage : ems_pkg

// File: test/ems_phy_model.sv
/*
  Stand-in for the PHY on the far side of the management link.
  Assumes the bench resolves the data line with a pull-up and a clock
  shared with the block, so the edges of the management clock are found
  by sampling.
*/
`timescale 1ns/1ps
module ems_phy_model (
  input  wire logic        clk,       // System clock, finds edges
  input  wire logic        mdc,       // Management clock from the block
  input  wire logic        mdio,      // Resolved data line
  output logic             drive,     // High while the model drives
  output logic             bit_out,   // Level the model drives
  output logic [31:0]      last_frame // Last 32 bits seen on the line
);
  logic        mdc_q = 1'b0;  // Management clock one cycle late
  logic        line_q = 1'b1; // Line level before the latest edge
  logic        rd_ok = 1'b0;  // Valid read frame in progress
  logic [31:0] sh;            // Incoming frame bits
  logic [4:0]  sel;           // Register chosen by the frame
  int          cnt = 0;       // Rising edges seen in this frame
  logic [15:0] regs [32];     // Register file of the PHY
  initial begin
    drive = 1'b0;
    bit_out = 1'b1;
  end
  // Sample at each rise with the level before it, answer at each fall
  always @(posedge clk) begin
    mdc_q  <= mdc;
    line_q <= mdio;
    if (mdc && !mdc_q) begin
      sh = {sh[30:0], line_q};
      cnt = cnt + 1;
      // Header complete: start 01 and read code 10 make a read
      if (cnt == 16) begin
        rd_ok = (sh[15:12] == 4'h6);
        sel = sh[6:2];
      end
      // Frame complete: a write frame stores its data field
      if (cnt == 32) begin
        last_frame <= sh;
        if (sh[31:28] == 4'h5) regs[sh[22:18]] = sh[15:0];
        cnt = 0;
        rd_ok = 1'b0;
      end
    end
    // Released line falls back to the pull-up level
    if (!mdc && mdc_q) begin
      drive   <= rd_ok;
      bit_out <= rd_ok ? regs[sel][31-cnt] : 1'b1;
    end
  end
endmodule : ems_phy_model

// File: test/test_ems_core.sv
/*
  Self-checking bench for the status, interrupt and management block.
  Assumes the PHY stand-in and a pull-up on the shared data line.
*/
`timescale 1ns/1ps
module test_ems_core;
  import ems_pkg::*;
  logic        clk = 0, rst = 1, wr_s = 0, rd_s = 0; // Clock and strobes
  logic        link = 0, slot = 0;                   // Level inputs
  logic [7:0]  addr = 0;                             // Register address
  logic [9:0]  ev = 0;                               // Event pulses
  logic [31:0] wdata = 0, rdata, rx_ptr, frame;      // Bus and views
  logic [31:0] v, w, r;                              // Scratch values
  logic        mdio_o, mdio_oe, mdc, crc_bad, reclaim, irq;
  logic        drv, pbit, line, oe_seen = 1'b0;      // Line and model
  int          mismatches = 0, checked = 0, seed = 14, n;
  // Pending bit raised by each event pulse, in pulse order
  localparam int BITS [9] = '{IRQ_TX_UND, IRQ_RX_NOBUF, IRQ_RX_COMP,
    IRQ_RX_OVR, IRQ_TX_COMP, IRQ_TX_ALL, IRQ_RETRY, IRQ_ABORT, IRQ_TX_QOVR};
  always #2.5 clk = ~clk;
  // Wired line: either party pulls low, otherwise the pull-up wins
  assign line = (mdio_oe ? mdio_o : 1'b1) & (drv ? pbit : 1'b1);
  ems_core i_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .TX_UNDERRUN(ev[0]),
    .RX_DESC_FAIL(ev[1]), .RX_STORED(ev[2]), .RX_OVERRUN(ev[3]),
    .TX_DONE(ev[4]), .TX_ALL_DONE(ev[5]), .TX_RETRY(ev[6]),
    .DMA_ABORT(ev[7]), .TX_WRITE(ev[8]), .RX_DESC_OK(ev[9]),
    .TX_SLOT_FREE(slot), .LINK(link), .MDIO_I(line), .MDIO_O(mdio_o),
    .MDIO_OE(mdio_oe), .MDC(mdc), .CRC_CORRUPT(crc_bad),
    .RX_RECLAIM(reclaim), .RX_PTR(rx_ptr), .IRQ(irq));
  ems_phy_model i_phy (.clk(clk), .mdc(mdc), .mdio(line), .drive(drv),
    .bit_out(pbit), .last_frame(frame));
  // Builds a management frame: start 01, PHY 0, turnaround 10
  function automatic logic [31:0] mgmt_word(input logic [1:0] op,
    input logic [4:0] rg, input logic [15:0] d);
    return {2'b01, op, 5'h00, rg, 2'b10, d};
  endfunction : mgmt_word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1;
    @(posedge clk);
    wr_s <= 0;
  endtask : bus_wr
  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1;
    @(posedge clk);
    rd_s <= 0;
    #1 d = rdata;
  endtask : bus_rd
  // One-cycle event, then catch the side-effect pulses
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1;
    @(posedge clk);
    ev[i] <= 0;
    #1 v = 32'({crc_bad, reclaim});
  endtask : pulse
  // Poll the busy bit, bounded; also note any drive of the line
  task automatic wait_idle;
    for (n = 0; n < 3000; n++) begin
      bus_rd(OFS_MGMT_STATUS, v);
      oe_seen |= mdio_oe;
      if (v[2] === 1'b0) break;
    end
    if (n == 3000) begin
      mismatches++;
      finish_test;
    end
  endtask : wait_idle
  task automatic mgmt(input logic [31:0] word);
    bus_wr(OFS_PHY_MGMT_FRAME, word);
    bus_rd(OFS_MGMT_STATUS, v);
    chk(32'(v[2]), 32'h1);
    wait_idle;
  endtask : mgmt
  task automatic finish_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    // Reset values and an unmapped place
    bus_rd(OFS_IRQ_DISABLED_VIEW, v);
    chk(v, 32'h0000_0FFF);
    bus_rd(OFS_MGMT_CONTROL, v);
    chk(v, 32'h0000_0004);
    bus_rd(8'hFC, v);
    chk(v, 32'h0);
    // Random enable and disable words against the mask view
    w = 32'hFFF;
    repeat (6) begin
      v = $random(seed);
      bus_wr(OFS_IRQ_ENABLE_SET, v);
      w &= ~v;
      v = $random(seed) & $random(seed);
      bus_wr(OFS_IRQ_ENABLE_CLEAR, v);
      w |= v;
      bus_rd(OFS_IRQ_DISABLED_VIEW, v);
      chk(v, w & 32'hFFF);
    end
    // All nine pulsed event sources: pending bit, interrupt line, clear on read
    bus_wr(OFS_IRQ_ENABLE_CLEAR, 32'hFFF);
    for (int i = 0; i < 9; i++) begin
      bus_wr(OFS_IRQ_ENABLE_SET, 32'h1 << BITS[i]);
      pulse(i);
      chk(v, i == 0 ? 32'h2 : i == 3 ? 32'h1 : 32'h0);
      repeat (2) @(posedge clk);
      #1 chk(32'(irq), 32'h1);
      bus_rd(OFS_IRQ_PENDING, v);
      chk(v, 32'h1 << BITS[i]);
      bus_rd(OFS_IRQ_PENDING, v);
      chk(v, 32'h0);
      chk(32'(irq), 32'h0);
    end
    // Receive flags stay until a one is written; failure sets again
    bus_rd(OFS_RX_EVENT_FLAGS, v);
    chk(v, 32'h7);
    bus_wr(OFS_RX_EVENT_FLAGS, 32'h1);
    bus_rd(OFS_RX_EVENT_FLAGS, v);
    chk(v, 32'h6);
    pulse(1);
    bus_rd(OFS_RX_EVENT_FLAGS, v);
    chk(v, 32'h7);
    bus_wr(OFS_RX_EVENT_FLAGS, 32'h7);
    bus_rd(OFS_RX_EVENT_FLAGS, v);
    chk(v, 32'h0);
    bus_rd(OFS_IRQ_PENDING, v);
    // Slot free rising, write while free, then a link change
    @(posedge clk) slot <= 1;
    bus_rd(OFS_IRQ_PENDING, v);
    chk(v, 32'h1 << IRQ_TX_FREE);
    pulse(8);
    bus_rd(OFS_IRQ_PENDING, v);
    chk(v, 32'h0);
    @(posedge clk) slot <= 0;
    link <= 1;
    repeat (3) @(posedge clk);
    bus_rd(OFS_IRQ_PENDING, v);
    chk(v, 32'h1 << IRQ_LINK);
    // Queue pointer: word aligned, advanced by a taken descriptor
    w = $random(seed);
    bus_wr(OFS_RX_QUEUE_POINTER, w);
    bus_rd(OFS_RX_QUEUE_POINTER, v);
    chk(v, w & ~32'h3);
    pulse(9);
    bus_rd(OFS_RX_QUEUE_POINTER, v);
    chk(v, (w & ~32'h3) + 32'h8);
    chk(rx_ptr, (w & ~32'h3) + 32'h8);
    // Write frame, a second write while busy, then a read frame
    bus_wr(OFS_MGMT_CONTROL, 32'h1);
    w = mgmt_word(2'b01, 5'h03, 16'($random(seed)));
    bus_wr(OFS_PHY_MGMT_FRAME, w);
    mgmt(~w);
    chk(frame, w);
    bus_rd(OFS_IRQ_PENDING, v);
    chk(v & 32'h1, 32'h1);
    r = mgmt_word(2'b10, 5'h03, 16'hFFFF);
    mgmt(r);
    bus_rd(OFS_PHY_MGMT_FRAME, v);
    chk(v, {r[31:16], w[15:0]});
    // Each divider code sets the management clock high time
    for (int d = 0; d < 4; d++) begin
      bus_wr(OFS_MGMT_CONTROL, 32'(d * 2 + 1));
      bus_wr(OFS_PHY_MGMT_FRAME, w);
      #1;
      for (n = 0; n < 200 && mdc !== 1'b1; n++) @(posedge clk) #1;
      for (n = 0; n < 600 && mdc === 1'b1; n++) @(posedge clk) #1;
      chk(32'(n), 32'h4 << d);
      wait_idle;
    end
    // Port off: the block never drives the line during a frame
    bus_wr(OFS_MGMT_CONTROL, 32'h0);
    oe_seen = 0;
    mgmt(w);
    chk(32'(oe_seen), 32'h0);
    finish_test;
  end
endmodule : test_ems_core
